// ==== scl_defines.svh ====
// register offsets, reset values and speed limits of the speed command limiter
`ifndef SCL_DEFINES_SVH
`define SCL_DEFINES_SVH
// ****************************************
// register byte offsets
// ****************************************
`define SCL_OFS_MAX 8'h00
`define SCL_OFS_MIN 8'h04
`define SCL_OFS_START 8'h08
`define SCL_OFS_JOG 8'h0C
`define SCL_OFS_JUMP0 8'h10
`define SCL_OFS_CTRL 8'h28
`define SCL_OFS_MOTOR 8'h2C
`define SCL_OFS_STAT 8'h30
`define SCL_OFS_TARGET 8'h34
// ****************************************
// reset values and limits in r/min
// ****************************************
`define SCL_RST_MAX 16'h0BB8
`define SCL_RST_MIN 16'h0000
`define SCL_RST_START 16'h0000
`define SCL_RST_JOG 16'h0096
`define SCL_RST_MOTOR 16'h0BB8
`define SCL_JUMP_OFF 16'h270F
`define SCL_ROT_CAP 16'h0BB8
`define SCL_SET_CAP 16'h12C0
`define SCL_GEAR_CAP_SMALL 16'h2EE0
`define SCL_GEAR_CAP_LARGE 16'h1F40
// ****************************************
// control bit positions
// ****************************************
`define SCL_CTRL_POS 0
`define SCL_CTRL_GEARED 1
`define SCL_CTRL_LARGE 2
`endif

// ==== scl_pkg.sv ====
// types shared by the speed command limiter
package scl_pkg;
  typedef logic [15:0] scl_speed_t;
  // control word: position mode, geared motor, largest drive rating
  typedef struct packed {
    logic large_cap;
    logic geared;
    logic pos_mode;
  } scl_ctrl_t;
  // sticky-free status of the last computed target
  typedef struct packed {
    logic jumped;
    logic min_clamped;
    logic max_clamped;
  } scl_stat_t;
endpackage

// ==== scl_speed_limiter.sv ====
// speed command limiter: max/min clamp, motor range and jump bands behind APB
// Contract
// - command above the maximum setting is clamped to it; maximum resets to 3000
// - settings accept 0 to 4800; rotation never exceeds 3000 for standard motor
// - geared motor: setting ceiling 12000, or 8000 on the largest rating
// - command also clamped to the selected motor's own maximum speed
// - speed held at minimum setting when set speed is lower; resets to 0
// - jog speed at or below minimum overrides the minimum clamp
// - position control disables the minimum clamp
// - active torque limiting lets speed drop below the minimum
// - start alone runs at minimum when minimum is at least starting speed
// - three jump bands of A and B points; 9999 resets and disables a band
// - ramps pass through a jump band instead of skipping it
// - position control disables every jump band
//
// Chosen here: the register addresses and the APB register port.
`include "scl_defines.svh"

module scl_speed_limiter
  import scl_pkg::*;
#(
  parameter int NBAND = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scl_speed_t speed_cmd,
  input wire logic cmd_valid,
  input wire logic start_on,
  input wire logic jog_on,
  input wire logic torque_limit_active,
  output scl_speed_t speed_target,
  output scl_stat_t limit_status
);

  // ****************************************
  // settings
  // ****************************************
  scl_speed_t max_speed_setting;
  scl_speed_t min_speed_setting;
  scl_speed_t starting_speed_setting;
  scl_speed_t jog_speed_setting;
  scl_speed_t motor_max_speed;
  scl_speed_t jump_point [2*NBAND];
  scl_ctrl_t ctrl;
  scl_speed_t next_max;
  scl_speed_t next_min;
  scl_speed_t next_start;
  scl_speed_t next_jog;
  scl_speed_t next_motor;
  scl_speed_t next_jump [2*NBAND];
  scl_ctrl_t next_ctrl;
  scl_speed_t set_cap;
  logic wr;
  logic rd_hit;

  // ceiling of any written value depends on motor type
  function automatic scl_speed_t cap_of(input scl_ctrl_t c);
    if (!c.geared) begin
      return `SCL_SET_CAP;
    end
    return c.large_cap ? `SCL_GEAR_CAP_LARGE : `SCL_GEAR_CAP_SMALL;
  endfunction

  // smaller of two speeds, used by several clamps
  function automatic scl_speed_t min2(input scl_speed_t a, input scl_speed_t b);
    return (a < b) ? a : b;
  endfunction

  assign set_cap = cap_of(ctrl);
  assign wr = psel && penable && pwrite;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  // next register values; out-of-range writes are dropped, old value kept
  always_comb begin
    next_max = max_speed_setting;
    next_min = min_speed_setting;
    next_start = starting_speed_setting;
    next_jog = jog_speed_setting;
    next_motor = motor_max_speed;
    next_ctrl = ctrl;
    for (int i = 0; i < 2*NBAND; i++) begin
      next_jump[i] = jump_point[i];
    end
    if (wr && pwdata[15:0] <= set_cap) begin
      case (paddr)
        `SCL_OFS_MAX: next_max = pwdata[15:0];
        `SCL_OFS_MIN: next_min = pwdata[15:0];
        `SCL_OFS_START: next_start = pwdata[15:0];
        `SCL_OFS_JOG: next_jog = pwdata[15:0];
        `SCL_OFS_MOTOR: next_motor = pwdata[15:0];
        default: next_max = max_speed_setting;
      endcase
    end
    for (int i = 0; i < 2*NBAND; i++) begin
      if (wr && paddr == 8'(`SCL_OFS_JUMP0 + 4*i)
          && (pwdata[15:0] <= set_cap || pwdata[15:0] == `SCL_JUMP_OFF)) begin
        next_jump[i] = pwdata[15:0];
      end
    end
    if (wr && paddr == `SCL_OFS_CTRL) begin
      next_ctrl = scl_ctrl_t'(pwdata[2:0]);
    end
  end

  // settings registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_speed_setting <= `SCL_RST_MAX;
      min_speed_setting <= `SCL_RST_MIN;
      starting_speed_setting <= `SCL_RST_START;
      jog_speed_setting <= `SCL_RST_JOG;
      motor_max_speed <= `SCL_RST_MOTOR;
      ctrl <= '0;
      for (int i = 0; i < 2*NBAND; i++) begin
        jump_point[i] <= `SCL_JUMP_OFF;
      end
    end else begin
      max_speed_setting <= next_max;
      min_speed_setting <= next_min;
      starting_speed_setting <= next_start;
      jog_speed_setting <= next_jog;
      motor_max_speed <= next_motor;
      ctrl <= next_ctrl;
      for (int i = 0; i < 2*NBAND; i++) begin
        jump_point[i] <= next_jump[i];
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    prdata = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      `SCL_OFS_MAX: prdata[15:0] = max_speed_setting;
      `SCL_OFS_MIN: prdata[15:0] = min_speed_setting;
      `SCL_OFS_START: prdata[15:0] = starting_speed_setting;
      `SCL_OFS_JOG: prdata[15:0] = jog_speed_setting;
      `SCL_OFS_MOTOR: prdata[15:0] = motor_max_speed;
      `SCL_OFS_CTRL: prdata[2:0] = ctrl;
      `SCL_OFS_STAT: prdata[2:0] = limit_status;
      `SCL_OFS_TARGET: prdata[15:0] = speed_target;
      default: rd_hit = 1'b0;
    endcase
    for (int i = 0; i < 2*NBAND; i++) begin
      if (paddr == 8'(`SCL_OFS_JUMP0 + 4*i)) begin
        prdata[15:0] = jump_point[i];
        rd_hit = 1'b1;
      end
    end
  end

  // unmapped addresses answer with an error, nothing is stored
  assign pslverr = psel && penable && !rd_hit;

  // ****************************************
  // jump bands
  // ****************************************
  logic [NBAND-1:0] band_hit;
  scl_speed_t band_lo [NBAND];
  scl_speed_t jump_cmd;
  logic jumped;

  // A and B may be written in either order; 9999 on either side disables
  for (genvar b = 0; b < NBAND; b++) begin : g_band
    scl_speed_t pa;
    scl_speed_t pb;
    scl_speed_t hi;
    assign pa = jump_point[2*b];
    assign pb = jump_point[2*b+1];
    assign band_lo[b] = min2(pa, pb);
    assign hi = (pa < pb) ? pb : pa;
    assign band_hit[b] = pa != `SCL_JUMP_OFF && pb != `SCL_JUMP_OFF
                         && speed_cmd > band_lo[b] && speed_cmd < hi;
  end

  // only the steady target is moved; the ramp behind it sweeps
  // through a band freely, so no running speed is touched here
  always_comb begin
    jump_cmd = speed_cmd;
    jumped = 1'b0;
    for (int b = NBAND - 1; b >= 0; b--) begin
      if (band_hit[b] && !ctrl.pos_mode) begin
        jump_cmd = band_lo[b];
        jumped = 1'b1;
      end
    end
  end

  // ****************************************
  // clamps
  // ****************************************
  scl_speed_t rot_cap;
  scl_speed_t eff_max;
  scl_speed_t base_cmd;
  scl_speed_t next_target;
  scl_stat_t next_status;
  logic jog_below_min;
  logic min_on;

  // standard motor never turns above 3000 whatever the setting
  assign rot_cap = ctrl.geared ? set_cap : `SCL_ROT_CAP;
  assign eff_max = min2(min2(max_speed_setting, rot_cap), motor_max_speed);
  assign jog_below_min = jog_speed_setting <= min_speed_setting;

  // minimum is skipped for position mode, torque limit or a low jog
  assign min_on = !ctrl.pos_mode
                  && !torque_limit_active
                  && !(jog_on && jog_below_min);

  // jog has precedence; start with no command asks for zero, so min wins
  always_comb begin
    base_cmd = jog_on ? jog_speed_setting : (cmd_valid ? jump_cmd : 16'h0000);
    next_status = '0;
    next_status.jumped = jumped && !jog_on && cmd_valid;
    next_target = base_cmd;
    if (min_on && base_cmd < min_speed_setting) begin
      next_target = min_speed_setting;
      next_status.min_clamped = 1'b1;
    end
    // maximum is applied after the minimum so that no path exceeds it; only the stop override to zero follows
    if (next_target > eff_max) begin
      next_target = eff_max;
      next_status.max_clamped = 1'b1;
    end
    if (!start_on && !jog_on) begin
      next_target = 16'h0000;
      next_status = '0;
    end
  end

  // target handed to the acceleration loop, one cycle after its inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_target <= 16'h0000;
      limit_status <= '0;
    end else begin
      speed_target <= next_target;
      limit_status <= next_status;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  // inputs sampled at one edge are judged against the target registered at the next
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_MAX_CLAMP: assert property (1'b1 |=> speed_target <= $past(max_speed_setting))
    else $error("target above maximum setting");
  AST_ROT_CAP: assert property (!ctrl.geared |=> speed_target <= `SCL_ROT_CAP)
    else $error("standard motor target above 3000");
  AST_WR_CAP: assert property ((wr && paddr == `SCL_OFS_MAX && pwdata[15:0] > set_cap)
      |=> $stable(max_speed_setting))
    else $error("out-of-range maximum accepted");
  AST_MOTOR_MAX: assert property (1'b1 |=> speed_target <= $past(motor_max_speed))
    else $error("target above motor maximum");
  AST_MIN_HOLD: assert property ((start_on && !jog_on && min_on && min_speed_setting <= eff_max)
      |=> speed_target >= $past(min_speed_setting))
    else $error("target below minimum setting");
  AST_JOG_LOW: assert property ((jog_on && jog_below_min && jog_speed_setting <= eff_max)
      |=> speed_target == $past(jog_speed_setting))
    else $error("low jog speed not used");
  AST_POS_PASS: assert property ((ctrl.pos_mode && start_on && !jog_on && cmd_valid
      && speed_cmd <= eff_max) |=> speed_target == $past(speed_cmd))
    else $error("position mode command altered");
  AST_TORQUE: assert property ((torque_limit_active && start_on && !jog_on && cmd_valid
      && jump_cmd <= eff_max) |=> speed_target == $past(jump_cmd))
    else $error("minimum enforced under torque limit");
  AST_START_MIN: assert property ((start_on && !jog_on && !cmd_valid && min_on
      && min_speed_setting >= starting_speed_setting && min_speed_setting <= eff_max)
      |=> speed_target == $past(min_speed_setting))
    else $error("start alone did not run at minimum");
  AST_JUMP_LOW: assert property ((start_on && !jog_on && cmd_valid && |band_hit && !ctrl.pos_mode)
      |=> limit_status.jumped && (speed_target < $past(speed_cmd) || limit_status.min_clamped))
    else $error("command left inside jump band");
  AST_POS_NOJUMP: assert property (ctrl.pos_mode |=> !limit_status.jumped)
    else $error("jump band applied in position mode");
  AST_JUMP_CAP: assert property ((wr && paddr == `SCL_OFS_JUMP0 && pwdata[15:0] > set_cap
      && pwdata[15:0] != `SCL_JUMP_OFF) |=> $stable(jump_point[0]))
    else $error("out-of-range jump point accepted");

  // main scenarios: each clamp, a jump, a low jog and position mode
  COV_MAX: cover property (start_on ##1 limit_status.max_clamped);
  COV_MIN: cover property (start_on ##1 limit_status.min_clamped);
  COV_JUMP: cover property (start_on && cmd_valid ##1 limit_status.jumped);
  COV_JOG: cover property (jog_on && jog_below_min);
  COV_POS: cover property (ctrl.pos_mode && start_on && cmd_valid);

endmodule // scl_speed_limiter

// ==== scl_drive_loop.sv ====
// behavioural drive speed loop that ramps toward the limiter target
module scl_drive_loop
  import scl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire scl_speed_t speed_target,
  output scl_speed_t loop_speed
);
  timeunit 1ns;
  timeprecision 1ns;
  // fixed ramp step; the ramp crosses any jump band instead of skipping it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) loop_speed <= 16'h0000;
    else if (loop_speed + 16'h0032 <= speed_target) loop_speed <= loop_speed + 16'h0032;
    else if (loop_speed >= speed_target + 16'h0032) loop_speed <= loop_speed - 16'h0032;
    else loop_speed <= speed_target;
  end
endmodule // scl_drive_loop

// ==== scl_speed_limiter_tb.sv ====
// self-checking bench of the speed command limiter
`include "scl_defines.svh"
module scl_speed_limiter_tb
  import scl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] RUN = 4'hC;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  scl_speed_t speed_cmd, speed_target, loop_speed;
  logic cmd_valid, start_on, jog_on, torque_limit_active;
  scl_stat_t limit_status;
  int fails, cmp_count;
  scl_speed_limiter i_scl_speed_limiter (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_cmd(speed_cmd), .cmd_valid(cmd_valid), .start_on(start_on), .jog_on(jog_on),
    .torque_limit_active(torque_limit_active), .speed_target(speed_target), .limit_status(limit_status));
  scl_drive_loop i_scl_drive_loop (.pclk(pclk), .presetn(presetn), .speed_target(speed_target),
    .loop_speed(loop_speed));
  // 10 MHz clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // ****************************************
  // bus and compare tasks
  // ****************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // compares of register words and of the speed path result
  task automatic chk_reg(input string n, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic chk_out(input string n, input logic [18:0] exp, input logic [18:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  // apb transfer: request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input scl_speed_t d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {16'h0000, d}, q, e);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input scl_speed_t exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk_reg(n, {16'h0000, exp}, q);
    chk_reg({n, "_err"}, 32'h00000000, {31'h00000000, e});
  endtask
  // drive the command inputs, let one edge register the target, check it
  task automatic spd(input scl_speed_t c, input logic [3:0] f, input scl_speed_t exp, input scl_stat_t st);
    @(posedge pclk);
    speed_cmd <= c;
    {cmd_valid, start_on, jog_on, torque_limit_active} <= f;
    @(posedge pclk);
    @(negedge pclk);
    chk_out("target_status", {exp, st}, {speed_target, limit_status});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    spd(16'h0000, 4'h0, 16'h0000, 3'h0);
    rd("max", `SCL_OFS_MAX, `SCL_RST_MAX);
    rd("min", `SCL_OFS_MIN, `SCL_RST_MIN);
    rd("start", `SCL_OFS_START, `SCL_RST_START);
    rd("jog", `SCL_OFS_JOG, `SCL_RST_JOG);
    rd("motor", `SCL_OFS_MOTOR, `SCL_RST_MOTOR);
    for (int i = 0; i < 6; i++) rd("jump", 8'(`SCL_OFS_JUMP0 + 4 * i), `SCL_JUMP_OFF);
  endtask
  task automatic t_max();
    wr(`SCL_OFS_MAX, 16'h12C0);
    rd("max", `SCL_OFS_MAX, 16'h12C0);
    wr(`SCL_OFS_MAX, 16'h12C1);
    rd("max", `SCL_OFS_MAX, 16'h12C0);
    spd(16'h1388, RUN, `SCL_ROT_CAP, 3'h1);
    wr(`SCL_OFS_MAX, 16'h07D0);
    spd(16'h09C4, RUN, 16'h07D0, 3'h1);
    spd(16'h0708, RUN, 16'h0708, 3'h0);
    wr(`SCL_OFS_MOTOR, 16'h05DC);
    spd(16'h0708, RUN, 16'h05DC, 3'h1);
    wr(`SCL_OFS_MOTOR, `SCL_RST_MOTOR);
    wr(`SCL_OFS_MAX, `SCL_RST_MAX);
  endtask
  // minimum clamp and the cases that bypass it
  task automatic t_min();
    wr(`SCL_OFS_MIN, 16'h01F4);
    spd(16'h00C8, RUN, 16'h01F4, 3'h2);
    spd(16'h00C8, 4'hD, 16'h00C8, 3'h0);
    spd(16'h0000, 4'h4, 16'h01F4, 3'h2);
    spd(16'h00C8, 4'h8, 16'h0000, 3'h0);
    spd(16'h0000, 4'h6, `SCL_RST_JOG, 3'h0);
    wr(`SCL_OFS_JOG, 16'h0258);
    spd(16'h0000, 4'h6, 16'h0258, 3'h0);
    wr(`SCL_OFS_CTRL, 16'h0001);
    spd(16'h00C8, RUN, 16'h00C8, 3'h0);
    wr(`SCL_OFS_CTRL, 16'h0000);
    wr(`SCL_OFS_MIN, 16'h0000);
  endtask
  // a band needs both points set; edges are outside the band
  task automatic t_jump();
    int n;
    logic seen;
    wr(`SCL_OFS_JUMP0, 16'h03E8);
    spd(16'h044C, RUN, 16'h044C, 3'h0);
    wr(`SCL_OFS_JUMP0 + 8'h04, 16'h04B0);
    spd(16'h044C, RUN, 16'h03E8, 3'h4);
    spd(16'h04B0, RUN, 16'h04B0, 3'h0);
    wr(`SCL_OFS_JUMP0, 16'h12C1);
    rd("jump", `SCL_OFS_JUMP0, 16'h03E8);
    wr(`SCL_OFS_JUMP0 + 8'h10, 16'h0898);
    wr(`SCL_OFS_JUMP0 + 8'h14, 16'h07D0);
    spd(16'h0834, RUN, 16'h07D0, 3'h4);
    wr(`SCL_OFS_MAX, 16'h041A);
    spd(16'h044C, RUN, 16'h03E8, 3'h4);
    for (n = 0; n < 200 && loop_speed !== speed_target; n++) @(posedge pclk);
    chk_reg("loop_speed", 32'h000003E8, {16'h0000, loop_speed});
    wr(`SCL_OFS_MAX, `SCL_RST_MAX);
    // command above the band: the ramp from its lower edge must cross it
    spd(16'h0514, RUN, 16'h0514, 3'h0);
    seen = 1'b0;
    for (n = 0; n < 20; n++) begin
      @(negedge pclk);
      seen = seen | (loop_speed > 16'h03E8 && loop_speed < 16'h04B0);
    end
    chk_reg("ramp_in_band", 32'h00000001, {31'h00000000, seen});
    wr(`SCL_OFS_CTRL, 16'h0001);
    spd(16'h044C, RUN, 16'h044C, 3'h0);
  endtask
  // geared ceilings, then refused writes and the unmapped place
  task automatic t_geared();
    logic [31:0] q;
    logic e;
    wr(`SCL_OFS_CTRL, 16'h0002);
    wr(`SCL_OFS_MAX, `SCL_GEAR_CAP_SMALL);
    wr(`SCL_OFS_MOTOR, `SCL_GEAR_CAP_SMALL);
    rd("max", `SCL_OFS_MAX, `SCL_GEAR_CAP_SMALL);
    spd(16'h2328, RUN, 16'h2328, 3'h0);
    wr(`SCL_OFS_CTRL, 16'h0006);
    wr(`SCL_OFS_MAX, 16'h2328);
    rd("max", `SCL_OFS_MAX, `SCL_GEAR_CAP_SMALL);
    spd(16'h2328, RUN, `SCL_GEAR_CAP_LARGE, 3'h1);
    rd("target", `SCL_OFS_TARGET, `SCL_GEAR_CAP_LARGE);
    rd("status", `SCL_OFS_STAT, 16'h0001);
    apb(1'b1, 8'h3C, 32'h00000001, q, e);
    chk_reg("unmapped_err", 32'h00000001, {31'h00000000, e});
    chk_reg("unmapped_data", 32'h00000000, q);
  endtask
  // reset for three cycles, then every scenario in turn
  initial begin
    {presetn, psel, penable, pwrite, cmd_valid, start_on, jog_on, torque_limit_active} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    speed_cmd = 16'h0000;
    fails = 0;
    cmp_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_max();
    t_min();
    t_jump();
    t_geared();
    stop_test();
  end
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #1000000;
    fails++;
    stop_test();
  end
endmodule // scl_speed_limiter_tb
